// File: verilog/i2sc_regs.svh
`ifndef I2SC_REGS_SVH
`define I2SC_REGS_SVH
// Width of the baud reload value
`define I2SC_RELOAD_W      7
// Reset value of the baud rate counter
`define I2SC_COUNT_RST     7'h00
// Open-drain release level
`define I2SC_LINE_HIGH     1'b1
`endif

// File: verilog/i2sc_pkg.sv
package i2sc_pkg;
	// Start generator states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_CHECK = 4'h2,
		ST_SDA   = 4'h4,
		ST_SCL   = 4'h8
	} i2sc_state_type;
endpackage

// File: verilog/i2sc_start_hold.sv
`timescale 1ns/1ns
`include "i2sc_regs.svh"

// Notes on behaviour
// R1: Hold clock low only after sampling it low
// R2: Release held clock when release bit sets
// R3: Watch both lines at the request and through the first count
// R4: Either line low at start means collision
// R5: Clock low before data driven is collision
// R6: Collision aborts start, flags, returns idle
// R7: Start on released lines, load reload value
// R8: Data low in first count: drive early
// R9: First count expires: drive data, reload
// R10: Clock low in second count is fine
// R11: Second count expiry drives clock low
// R12: Simultaneous data-low starts are not collisions
// R13: Counter decrements each cycle, expires at zero
module i2sc_start_hold #(
	parameter int RELOAD_W = `I2SC_RELOAD_W     // Reload width
) (
	input  wire logic                clk,                 // System clock
	input  wire logic                resetn,              // Async reset, active low
	input  wire logic                clk_en,              // Clock enable
	input  wire logic                start_req,           // Start request pulse
	input  wire logic [RELOAD_W-1:0] baud_reload_register, // Baud reload value
	input  wire logic                clock_release_bit,   // Clock release control
	input  wire logic                serial_data_pin_in,  // Data line level
	input  wire logic                serial_clock_pin_in, // Clock line level
	output logic                     serial_data_pin_out, // Data drive value
	output logic                     serial_data_pin_oe,  // Data drive enable
	output logic                     serial_clock_pin_out, // Clock drive value
	output logic                     serial_clock_pin_oe, // Clock drive enable
	output logic                     bus_collision_flag,  // Collision pulse
	output logic                     start_done,          // Start complete pulse
	output logic                     start_busy           // Start in progress
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] sda_sync_reg;  // Data line stages
	logic [1:0] scl_sync_reg;  // Clock line stages
	logic       sda_s;         // Synchronised data
	logic       scl_s;         // Synchronised clock

	// Two-stage capture of both lines
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sda_sync_reg <= 2'h3;
			scl_sync_reg <= 2'h3;
		end else if (clk_en) begin
			sda_sync_reg <= {sda_sync_reg[0], serial_data_pin_in};
			scl_sync_reg <= {scl_sync_reg[0], serial_clock_pin_in};
		end
	end

	assign sda_s = sda_sync_reg[1];
	assign scl_s = scl_sync_reg[1];

	// ----------------------------------------
	// Start generator
	// ----------------------------------------
	i2sc_pkg::i2sc_state_type state_reg;  // Current state
	i2sc_pkg::i2sc_state_type state_next; // Next state
	logic [RELOAD_W-1:0]      cnt_reg;    // Baud rate counter
	logic [RELOAD_W-1:0]      cnt_next;   // Counter next
	logic                     sda_drv_reg;  // Start drives data low
	logic                     sda_drv_next; // Next value
	logic                     scl_drv_reg;  // Start drives clock low
	logic                     scl_drv_next; // Next value
	logic                     bcl_reg;    // Collision pulse
	logic                     bcl_next;   // Next value
	logic                     done_reg;   // Done pulse
	logic                     done_next;  // Next value
	logic                     busy_reg;   // Start in progress
	logic                     busy_next;  // Next value
	logic                     expired;    // Counter at zero

	// Counter expiry decode
	assign expired = (cnt_reg == RELOAD_W'(`I2SC_COUNT_RST)); // R13

	// Busy follows the next state so the output comes from a flop
	assign busy_next = (state_next != i2sc_pkg::ST_IDLE);

	// Next-state logic for the start sequence
	always_comb begin
		state_next   = state_reg;
		cnt_next     = cnt_reg;
		sda_drv_next = sda_drv_reg;
		scl_drv_next = scl_drv_reg;
		bcl_next     = 1'b0;
		done_next    = 1'b0;
		unique case (state_reg)
			i2sc_pkg::ST_IDLE: begin
				sda_drv_next = 1'b0;
				if (start_req) begin
					// Lines must both be released
					if (!sda_s || !scl_s) begin
						bcl_next = 1'b1; // R4 R6
					end else begin
						cnt_next   = baud_reload_register; // R7
						state_next = i2sc_pkg::ST_CHECK;
					end
				end
			end
			i2sc_pkg::ST_CHECK: begin
				if (!scl_s && sda_s) begin
					// Another master drives a one
					bcl_next   = 1'b1; // R3 R5 R6
					state_next = i2sc_pkg::ST_IDLE;
				end else if (!sda_s) begin
					// Another master began first
					cnt_next     = baud_reload_register; // R8 R12
					sda_drv_next = 1'b1;
					state_next   = i2sc_pkg::ST_SDA;
				end else if (expired) begin
					cnt_next     = baud_reload_register; // R9
					sda_drv_next = 1'b1;
					state_next   = i2sc_pkg::ST_SDA;
				end else begin
					cnt_next = cnt_reg - 1'b1; // R13
				end
			end
			i2sc_pkg::ST_SDA: begin
				// Clock low here is not a collision
				if (expired) begin // R10
					scl_drv_next = 1'b1; // R11
					done_next    = 1'b1;
					state_next   = i2sc_pkg::ST_SCL;
				end else begin
					cnt_next = cnt_reg - 1'b1; // R13
				end
			end
			i2sc_pkg::ST_SCL: begin
				// Start complete; hand clock to hold logic
				scl_drv_next = 1'b0;
				state_next   = i2sc_pkg::ST_IDLE;
			end
		endcase
	end

	// Register the start sequence state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg   <= i2sc_pkg::ST_IDLE;
			cnt_reg     <= RELOAD_W'(`I2SC_COUNT_RST);
			sda_drv_reg <= 1'b0;
			scl_drv_reg <= 1'b0;
			bcl_reg     <= 1'b0;
			done_reg    <= 1'b0;
			busy_reg    <= 1'b0;
		end else if (clk_en) begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			sda_drv_reg <= sda_drv_next;
			scl_drv_reg <= scl_drv_next;
			bcl_reg     <= bcl_next;
			done_reg    <= done_next;
			busy_reg    <= busy_next;
		end
	end

	// ----------------------------------------
	// Slave clock hold
	// ----------------------------------------
	logic hold_reg;  // Holding clock low
	logic hold_next; // Next value

	// Catch only a clock already low; free on release bit
	always_comb begin
		hold_next = hold_reg;
		if (clock_release_bit) begin
			hold_next = 1'b0; // R2
		end else if (!scl_s) begin
			hold_next = 1'b1; // R1
		end
	end

	// Register the hold state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hold_reg <= 1'b0;
		end else if (clk_en) begin
			hold_reg <= hold_next;
		end
	end

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	logic scl_oe_reg; // Clock enable out
	logic sda_oe_reg; // Data enable out

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else if (clk_en) begin
			scl_oe_reg <= scl_drv_next | hold_next;
			sda_oe_reg <= sda_drv_next;
		end
	end

	assign serial_clock_pin_oe  = scl_oe_reg;
	assign serial_data_pin_oe   = sda_oe_reg;
	assign serial_clock_pin_out = 1'b0;
	assign serial_data_pin_out  = 1'b0;
	assign bus_collision_flag   = bcl_reg;
	assign start_done           = done_reg;
	assign start_busy           = busy_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_collision_idle: assert property (@(posedge clk) disable iff (!resetn) // R6
		(clk_en && bcl_reg) |-> state_reg == i2sc_pkg::ST_IDLE)
		else $error("collision did not return to idle");

	chk_hold_needs_low: assert property (@(posedge clk) disable iff (!resetn) // R1
		(clk_en && $rose(hold_reg)) |-> !$past(scl_s))
		else $error("clock held before it was low");

	chk_hold_release: assert property (@(posedge clk) disable iff (!resetn) // R2
		(clk_en && $past(clk_en) && $past(clock_release_bit)) |-> !hold_reg)
		else $error("clock hold not released");

	chk_start_clear: assert property (@(posedge clk) disable iff (!resetn) // R4
		(clk_en && state_reg == i2sc_pkg::ST_IDLE && start_req && (!sda_s || !scl_s))
		|=> bcl_reg)
		else $error("start on busy lines not flagged");

	chk_no_col_late: assert property (@(posedge clk) disable iff (!resetn) // R10
		(clk_en && state_reg == i2sc_pkg::ST_SDA) |=> !bcl_reg)
		else $error("collision flagged in second count");

	chk_scl_expiry: assert property (@(posedge clk) disable iff (!resetn) // R11
		(clk_en && state_reg == i2sc_pkg::ST_SDA && expired) |=> scl_oe_reg && done_reg)
		else $error("clock not driven at second expiry");

	chk_sda_drive: assert property (@(posedge clk) disable iff (!resetn) // R9
		(clk_en && state_reg == i2sc_pkg::ST_CHECK && expired && scl_s) |=> sda_oe_reg)
		else $error("data not driven at first expiry");

	chk_count_down: assert property (@(posedge clk) disable iff (!resetn) // R13
		(clk_en && state_reg == i2sc_pkg::ST_SDA && !expired) |=> cnt_reg == $past(cnt_reg) - 1'b1)
		else $error("counter did not decrement");

	// Clock seen low while data still high in the first count
	sequence seq_first_scl_low;
		clk_en && state_reg == i2sc_pkg::ST_CHECK && !scl_s && sda_s;
	endsequence

	// Data seen low in the first count
	sequence seq_first_sda_low;
		clk_en && state_reg == i2sc_pkg::ST_CHECK && !sda_s;
	endsequence

	chk_first_col: assert property (@(posedge clk) disable iff (!resetn) // R5
		seq_first_scl_low |=> bcl_reg && state_reg == i2sc_pkg::ST_IDLE)
		else $error("clock low in first count not flagged");

	chk_early_sda: assert property (@(posedge clk) disable iff (!resetn) // R8
		seq_first_sda_low |=> sda_oe_reg && cnt_reg == $past(baud_reload_register))
		else $error("data not driven early");

endmodule

// File: bench/i2sc_bus_peer.sv
`timescale 1ns/1ns
// ----------------------------------------
// Other bus master on the shared lines
// ----------------------------------------
module i2sc_bus_peer (
	input  wire logic want_sda, // Ask to pull data low
	input  wire logic want_scl, // Ask to pull clock low
	output logic      sda_low,  // Pulls data line low
	output logic      scl_low   // Pulls clock line low
);
	// Pulls follow requests that change after falling edges
	always_comb begin
		sda_low = want_sda;
		scl_low = want_scl;
	end
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ns
// ----------------------------------------
// Start generator and clock hold bench
// ----------------------------------------
module tb_top;
	logic       clk = 1'b0;   // System clock
	logic       resetn = 1'b0; // Reset, active low
	logic       start_req = 1'b0; // Start request
	logic       rel = 1'b1;   // Clock release control
	logic [6:0] reload = 7'h00; // Baud reload value
	logic       want_sda = 1'b0; // Peer data pull
	logic       want_scl = 1'b0; // Peer clock pull
	logic       p_sda, p_scl, sda_oe, scl_oe, col, done, busy; // Wires
	int         err_count = 0; // Mismatches
	int         tests_run = 0; // Comparisons
	int         seed = 77;    // Random seed
	int         n;            // Scratch reload
	always #10 clk = ~clk;
	i2sc_bus_peer peer_u (.want_sda(want_sda), .want_scl(want_scl),
		.sda_low(p_sda), .scl_low(p_scl));
	i2sc_start_hold dut_u (.clk(clk), .resetn(resetn), .clk_en(1'b1),
		.start_req(start_req), .baud_reload_register(reload),
		.clock_release_bit(rel), .serial_data_pin_in(~(sda_oe | p_sda)),
		.serial_clock_pin_in(~(scl_oe | p_scl)), .serial_data_pin_out(),
		.serial_data_pin_oe(sda_oe), .serial_clock_pin_out(),
		.serial_clock_pin_oe(scl_oe), .bus_collision_flag(col),
		.start_done(done), .start_busy(busy));
	// ----------------------------------------
	// Compare, wait and closing tasks
	// ----------------------------------------
	task automatic chk_num(input int got, input int exp);
		tests_run++;
		if (got != exp) begin
			err_count++;
			$display("mismatch at %0t: time %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: line %b expected %b", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("errors %0d, checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic wait_n(input int k);
		repeat (k) @(negedge clk);
	endtask
	// One start: peer pulls at cycles ks/kc, or before start
	task automatic scen(input int n, input int ks, input int kc, input bit ps, input bit pc);
		int i, ts, tc, td, tk, es, ec;
		bit ecol;
		ts = -1; tc = -1; td = -1; tk = -1;
		es = (ks > 0 && ks < n) ? ks + 2 : n + 1;
		ecol = ps | pc | (kc > 0 && kc + 2 <= es);
		ec = ecol ? -1 : es + n + 1;
		if (ecol) es = -1;
		want_sda = ps;
		want_scl = pc;
		wait_n(4);
		reload = n[6:0];
		start_req = 1'b1;
		@(negedge clk);
		start_req = 1'b0;
		if (col === 1'b1) tk = 0;
		for (i = 1; i < 2 * n + 12; i++) begin
			if (i == ks) want_sda = 1'b1;
			if (i == kc) want_scl = 1'b1;
			@(negedge clk);
			if (ts < 0 && sda_oe === 1'b1) ts = i;
			if (tc < 0 && scl_oe === 1'b1) tc = i;
			if (td < 0 && done === 1'b1) td = i;
			if (tk < 0 && col === 1'b1) tk = i;
		end
		chk_num(ts, es);
		chk_num(tc, ec);
		chk_num(td, ec);
		chk_num(int'(tk >= 0), int'(ecol));
		chk_bit(busy, 1'b0);
		want_sda = 1'b0;
		want_scl = 1'b0;
		wait_n(4);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		wait_n(20);
		resetn = 1'b1;
		wait_n(4);
		for (int j = 0; j < 6; j++) begin
			n = (j == 0) ? 0 : (j == 1) ? 127 : ($random(seed) & 8'h3F);
			scen(n, 0, 0, 1'b0, 1'b0);
		end
		scen(20, 5, 0, 1'b0, 1'b0);
		scen(20, 0, 3, 1'b0, 1'b0);
		scen(20, 0, 26, 1'b0, 1'b0);
		scen(10, 0, 0, 1'b0, 1'b1);
		scen(10, 0, 0, 1'b1, 1'b0);
		rel = 1'b0;
		wait_n(5);
		chk_bit(scl_oe, 1'b0);
		want_scl = 1'b1;
		wait_n(5);
		chk_bit(scl_oe, 1'b1);
		want_scl = 1'b0;
		wait_n(5);
		chk_bit(scl_oe, 1'b1);
		rel = 1'b1;
		wait_n(4);
		chk_bit(scl_oe, 1'b0);
		finish_test;
	end
	// Watchdog against a hung run
	initial begin
		#400000;
		err_count++;
		finish_test;
	end
endmodule
